// ==== rtl/cfg_pkg.sv ====
/*
 * constants for the option word decoder: field positions, reset values,
 * register offsets and oscillator set-up times.
 * assumes a 20 MHz aclk and a 32-bit axi4-lite register bus.
 */
package cfg_pkg;

	// ------------------------------------------------------------------
	// word sizes
	// ------------------------------------------------------------------
	localparam int W0_BITS = 13;
	localparam int W1_BITS = 2;
	localparam int ID_BITS = 13;

	// ------------------------------------------------------------------
	// word 0 field positions
	// ------------------------------------------------------------------
	localparam int RST_PIN_BIT = 12;
	localparam int WDT_BIT     = 11;
	localparam int IPER_BIT    = 10;
	localparam int OSC_HI_BIT  = 9;
	localparam int OSC_LO_BIT  = 8;
	localparam int SEC_BIT     = 7;
	localparam int SUT_HI_BIT  = 6;
	localparam int SUT_LO_BIT  = 5;
	localparam int TYPE_BIT    = 4;
	localparam int OUTPIN_BIT  = 3;
	localparam int TRIM_HI_BIT = 2;
	localparam int FREQ_HI_BIT = 1;

	// ------------------------------------------------------------------
	// values after reset (erased fuse image, part type 0)
	// ------------------------------------------------------------------
	localparam logic [12:0] W0_RST   = 13'h1FEF;
	localparam logic [1:0]  W1_RST   = 2'h3;
	localparam logic [12:0] ID_RST   = 13'h0000;
	localparam logic [2:0]  TRIM_REQ = 3'h7;
	localparam logic        TYPE_REQ = 1'h0;

	// ------------------------------------------------------------------
	// internal rc frequencies in khz
	// ------------------------------------------------------------------
	localparam logic [13:0] IRC_4M_KHZ   = 14'h0FA0;
	localparam logic [13:0] IRC_8M_KHZ   = 14'h1F40;
	localparam logic [13:0] IRC_1M_KHZ   = 14'h03E8;
	localparam logic [13:0] IRC_455K_KHZ = 14'h01C7;

	// ------------------------------------------------------------------
	// set-up times in microseconds, the clock rate and the supply detect level in millivolts
	// ------------------------------------------------------------------
	localparam int CLK_HZ       = 20_000_000;
	localparam int SUT_18MS_US  = 18000;
	localparam int SUT_4P5MS_US = 4500;
	localparam int SUT_288MS_US = 288000;
	localparam int SUT_72MS_US  = 72000;
	localparam int SUPPLY_DETECT_MV = 2000;

	// ------------------------------------------------------------------
	// register map and status fields
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_WORD0  = 8'h00;
	localparam logic [7:0] OFS_WORD1  = 8'h04;
	localparam logic [7:0] OFS_ID     = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_CTRL   = 8'h10;
	localparam int ST_LOADED    = 0;
	localparam int ST_TRIM_BAD  = 1;
	localparam int ST_TYPE_BAD  = 2;
	localparam int ST_GRANT     = 3;
	localparam int ST_MODE_LO   = 4;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		LOW_CRYSTAL,
		HIGH_CRYSTAL,
		EXTERNAL_RC,
		INTERNAL_RC
	} osc_mode_type;

	// microseconds to aclk cycles; exact at 20 MHz, so no rounding step
	function automatic int us_to_cycles(input int us);
		us_to_cycles = us * (CLK_HZ / 1_000_000);
	endfunction

endpackage

// ==== rtl/option_decode.sv ====
/*
 * combinational decode of the two option words into configuration fields.
 * assumes its caller registers the results once per power-on reset.
 */
`timescale 1ns/1ps
`default_nettype none
module option_decode #(
	parameter int SUT_18MS_CYC  = 360000,
	parameter int SUT_4P5MS_CYC = 90000,
	parameter int SUT_288MS_CYC = 5760000,
	parameter int SUT_72MS_CYC  = 1440000
) (
	input  wire logic [12:0]           word0,
	input  wire logic [1:0]            word1,
	output logic                       reset_pin_en,
	output logic                       watchdog_en,
	output logic                       instr_four_clk,
	output cfg_pkg::osc_mode_type      osc_mode,
	output logic                       code_secure,
	output logic [22:0]                setup_cycles,
	output logic                       oscillator_output,
	output logic [13:0]                irc_freq_khz,
	output logic                       trim_bad,
	output logic                       type_bad
);
	import cfg_pkg::*;

	// ------------------------------------------------------------------
	// single-bit fields and the 2-bit oscillator mode; reset pin, watchdog and security are active low in the word
	// ------------------------------------------------------------------
	assign reset_pin_en      = ~word0[RST_PIN_BIT];
	assign watchdog_en       = ~word0[WDT_BIT];
	assign instr_four_clk    = word0[IPER_BIT];
	assign code_secure       = ~word0[SEC_BIT];
	assign oscillator_output = word0[OUTPIN_BIT];
	assign osc_mode = osc_mode_type'(word0[OSC_HI_BIT:OSC_LO_BIT]);

	// programming-agent faults: reported only, never acted on
	assign trim_bad = word0[TRIM_HI_BIT:0] != TRIM_REQ;
	assign type_bad = word0[TYPE_BIT] != TYPE_REQ;

	// set-up delay select; codes are not monotonic in time
	always_comb begin
		unique case (word0[SUT_HI_BIT:SUT_LO_BIT])
			2'h3: setup_cycles = 23'(SUT_18MS_CYC);
			2'h2: setup_cycles = 23'(SUT_4P5MS_CYC);
			2'h1: setup_cycles = 23'(SUT_288MS_CYC);
			2'h0: setup_cycles = 23'(SUT_72MS_CYC);
		endcase
	end

	// internal rc frequency select
	always_comb begin
		unique case (word1)
			2'h3: irc_freq_khz = IRC_4M_KHZ;
			2'h2: irc_freq_khz = IRC_8M_KHZ;
			2'h1: irc_freq_khz = IRC_1M_KHZ;
			2'h0: irc_freq_khz = IRC_455K_KHZ;
		endcase
	end

endmodule
`default_nettype wire

// ==== rtl/option_word_config_decoder.sv ====
/*
 * holds the fuse option words, decodes them once per power-on reset and
 * shows them to the programming agent over axi4-lite.
 * assumes fuse words are stable while the supply is good, and that the
 * axi port belongs to the programming agent, not to the running core.
 */
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - internal rc mode runs at 4 MHz by default, field picks others.
// - word 1 code 11=4 MHz, 10=8 MHz, 01=1 MHz, 00=455 kHz.
// - option words lie outside program memory; core code cannot reach them.
// - three words: 13 option bits, 2 option bits, 13-bit customer id.
// - word 0 bit 12 low enables the reset pin, high disables it.
// - word 0 bit 11 low enables the watchdog, high disables it.
// - word 0 bit 10 low gives two clocks per instruction, high four.
// - bits 9:8 pick internal rc, external rc, high or low crystal.
// - word 0 bit 7 low turns security on and blocks program readout.
// - bits 6:5 pick set-up delay 18, 4.5, 288 or 72 ms.
// - word 0 bit 3 low makes the pin port bit 4, high oscillator out.
// - word 2 holds a customer id with no effect on behaviour.
// - internal power-on reset held while supply is below 2.0 V.
module option_word_config_decoder #(
	parameter int SUT_18MS_CYC  = cfg_pkg::us_to_cycles(cfg_pkg::SUT_18MS_US),
	parameter int SUT_4P5MS_CYC = cfg_pkg::us_to_cycles(cfg_pkg::SUT_4P5MS_US),
	parameter int SUT_288MS_CYC = cfg_pkg::us_to_cycles(cfg_pkg::SUT_288MS_US),
	parameter int SUT_72MS_CYC  = cfg_pkg::us_to_cycles(cfg_pkg::SUT_72MS_US)
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  supply_low,
	input  wire logic [12:0]           fuse_word0,
	input  wire logic [1:0]            fuse_word1,
	input  wire logic [12:0]           fuse_id,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [7:0]            awaddr,
	input  wire logic [2:0]            awprot,
	input  wire logic                  wvalid,
	output logic                       wready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	output logic                       bvalid,
	input  wire logic                  bready,
	output logic [1:0]                 bresp,
	input  wire logic                  arvalid,
	output logic                       arready,
	input  wire logic [7:0]            araddr,
	input  wire logic [2:0]            arprot,
	output logic                       rvalid,
	input  wire logic                  rready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       por_release_n,
	output logic                       reset_pin_en,
	output logic                       watchdog_en,
	output logic                       instr_four_clk,
	output cfg_pkg::osc_mode_type      osc_mode,
	output logic                       internal_rc_mode,
	output logic                       external_rc_mode,
	output logic                       high_crystal_mode,
	output logic                       low_crystal_mode,
	output logic                       code_secure,
	output logic [22:0]                setup_cycles,
	output logic                       oscillator_output,
	output logic                       port_bit_four_io,
	output logic [13:0]                irc_freq_khz,
	output logic [2:0]                 irc_trim_bits,
	output logic [12:0]                customer_id,
	output logic                       readout_grant
);
	import cfg_pkg::*;

	// ------------------------------------------------------------------
	// option store and decode
	// ------------------------------------------------------------------
	logic [12:0]  word0_r;
	logic [1:0]   word1_r;
	logic [12:0]  id_r;
	logic         loaded_r;
	logic         trim_bad_r;
	logic         type_bad_r;
	logic         readout_req_r;
	logic         capture;
	logic         d_rst_pin;
	logic         d_wdt;
	logic         d_iper;
	osc_mode_type d_mode;
	logic         d_sec;
	logic [22:0]  d_sut;
	logic         d_outpin;
	logic [13:0]  d_freq;
	logic         d_trim_bad;
	logic         d_type_bad;

	// decode straight from the fuses so outputs load in the capture cycle
	option_decode #(
		.SUT_18MS_CYC  (SUT_18MS_CYC),
		.SUT_4P5MS_CYC (SUT_4P5MS_CYC),
		.SUT_288MS_CYC (SUT_288MS_CYC),
		.SUT_72MS_CYC  (SUT_72MS_CYC)
	) u_decode (
		.word0             (fuse_word0),
		.word1             (fuse_word1),
		.reset_pin_en      (d_rst_pin),
		.watchdog_en       (d_wdt),
		.instr_four_clk    (d_iper),
		.osc_mode          (d_mode),
		.code_secure       (d_sec),
		.setup_cycles      (d_sut),
		.oscillator_output (d_outpin),
		.irc_freq_khz      (d_freq),
		.trim_bad          (d_trim_bad),
		.type_bad          (d_type_bad)
	);

	// capture once the supply is good and nothing has been taken yet
	assign capture = !loaded_r && !supply_low;

	// power-on sequencing; a brown-out drops the store back to unloaded
	always_ff @(posedge aclk) begin
		if (!aresetn || supply_low) begin
			loaded_r <= 1'b0;
		end else if (capture) begin
			loaded_r <= 1'b1;
		end
	end

	// raw words: only the fuse port writes them, never the bus
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word0_r <= W0_RST;
			word1_r <= W1_RST;
			id_r    <= ID_RST;
		end else if (capture) begin
			word0_r <= fuse_word0;
			word1_r <= fuse_word1;
			id_r    <= fuse_id;
		end
	end

	// decoded outputs held static between power-on resets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_pin_en      <= ~W0_RST[RST_PIN_BIT];
			watchdog_en       <= ~W0_RST[WDT_BIT];
			instr_four_clk    <= W0_RST[IPER_BIT];
			osc_mode          <= INTERNAL_RC;
			code_secure       <= ~W0_RST[SEC_BIT];
			setup_cycles      <= 23'(SUT_18MS_CYC);
			oscillator_output <= W0_RST[OUTPIN_BIT];
			irc_freq_khz      <= IRC_4M_KHZ;
			trim_bad_r        <= 1'b0;
			type_bad_r        <= 1'b0;
		end else if (capture) begin
			reset_pin_en      <= d_rst_pin;
			watchdog_en       <= d_wdt;
			instr_four_clk    <= d_iper;
			osc_mode          <= d_mode;
			code_secure       <= d_sec;
			setup_cycles      <= d_sut;
			oscillator_output <= d_outpin;
			irc_freq_khz      <= d_freq;
			trim_bad_r        <= d_trim_bad;
			type_bad_r        <= d_type_bad;
		end
	end

	// one-hot mode views and pin choice follow the held fields
	assign internal_rc_mode  = osc_mode == INTERNAL_RC;
	assign external_rc_mode  = osc_mode == EXTERNAL_RC;
	assign high_crystal_mode = osc_mode == HIGH_CRYSTAL;
	assign low_crystal_mode  = osc_mode == LOW_CRYSTAL;
	assign port_bit_four_io  = !oscillator_output;
	assign irc_trim_bits     = word0_r[TRIM_HI_BIT:0];
	assign customer_id       = id_r;
	assign por_release_n     = loaded_r;

	// readout is refused while security is on, whatever is requested
	assign readout_grant = readout_req_r && !code_secure && loaded_r;

	// ------------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------------
	logic        aw_got_r;
	logic        w_got_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic        aw_fire;
	logic        w_fire;
	logic        wr_do;
	logic        rd_fire;
	logic [31:0] rd_value;
	logic        rd_hit;

	// one write in flight: channels close until the response is taken
	assign awready = !aw_got_r && !bvalid_r;
	assign wready  = !w_got_r && !bvalid_r;
	assign aw_fire = awvalid && awready;
	assign w_fire  = wvalid && wready;
	assign wr_do   = aw_got_r && w_got_r && !bvalid_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = !rvalid_r;
	assign rd_fire = arvalid && arready;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;

	// address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
		end else begin
			if (aw_fire) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= awaddr;
			end else if (wr_do) begin
				aw_got_r <= 1'b0;
			end
			if (w_fire) begin
				w_got_r  <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end else if (wr_do) begin
				w_got_r <= 1'b0;
			end
		end
	end

	// only the control word is writable; option words are read-only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			readout_req_r <= 1'b0;
		end else if (wr_do && aw_addr_r == OFS_CTRL && w_strb_r[0]) begin
			readout_req_r <= w_data_r[0];
		end
	end

	// write response; every offset but the control word answers slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_do) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (aw_addr_r == OFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// read mux; reserved bits read as zero
	always_comb begin
		rd_value = 32'h00000000;
		rd_hit   = 1'b1;
		unique case (araddr)
			OFS_WORD0:  rd_value[12:0] = word0_r;
			OFS_WORD1:  rd_value[1:0]  = word1_r;
			OFS_ID:     rd_value[12:0] = id_r;
			OFS_STATUS: begin
				rd_value[ST_LOADED]   = loaded_r;
				rd_value[ST_TRIM_BAD] = trim_bad_r;
				rd_value[ST_TYPE_BAD] = type_bad_r;
				rd_value[ST_GRANT]    = readout_grant;
				rd_value[ST_MODE_LO +: 2] = osc_mode;
			end
			OFS_CTRL:   rd_value[0] = readout_req_r;
			default:    rd_hit = 1'b0;
		endcase
	end

	// read data registered; answer the cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_value;
			rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_taken;
		wr_do;
	endsequence

	sequence s_resp_up;
		bvalid ##1 (bvalid || $past(bready));
	endsequence

	AST_WR_RESP:
	assert property (s_wr_taken |=> s_resp_up)
		else $error("write response missing after address and data");

	AST_POR_HOLD:
	assert property (supply_low |=> !por_release_n ##1 (!por_release_n || !$past(supply_low)))
		else $error("power-on reset released during low supply");

	AST_STATIC:
	assert property (loaded_r && $past(loaded_r) |-> $stable(word0_r) && $stable(osc_mode)
		&& $stable(setup_cycles) && $stable(irc_freq_khz))
		else $error("configuration changed without power-on reset");

	AST_RST_PIN:
	assert property (loaded_r |-> reset_pin_en == !word0_r[RST_PIN_BIT])
		else $error("reset pin enable does not match word 0");

	AST_WDT:
	assert property (loaded_r |-> watchdog_en == !word0_r[WDT_BIT])
		else $error("watchdog enable does not match word 0");

	AST_IPER:
	assert property (loaded_r |-> instr_four_clk == word0_r[IPER_BIT])
		else $error("instruction period does not match word 0");

	AST_MODE:
	assert property (loaded_r |-> osc_mode == word0_r[OSC_HI_BIT:OSC_LO_BIT]
		&& $onehot({internal_rc_mode, external_rc_mode, high_crystal_mode, low_crystal_mode}))
		else $error("oscillator mode does not match word 0");

	AST_SECURE:
	assert property (code_secure |-> !readout_grant)
		else $error("readout granted while security is on");

	AST_SUT:
	assert property (loaded_r && word0_r[SUT_HI_BIT:SUT_LO_BIT] == 2'h1
		|-> setup_cycles == 23'(SUT_288MS_CYC))
		else $error("set-up delay wrong for code 01");

	AST_FREQ:
	assert property (loaded_r && word1_r == 2'h0 |-> irc_freq_khz == IRC_455K_KHZ)
		else $error("internal rc frequency wrong for code 00");

	AST_OUTPIN:
	assert property (port_bit_four_io != oscillator_output
		&& (!loaded_r || oscillator_output == word0_r[OUTPIN_BIT]))
		else $error("oscillator output pin choice wrong");

endmodule
`default_nettype wire

// ==== dv/tb_option_word_config_decoder.sv ====
/*
 * self-checking bench for the option word decoder: fuse images are captured
 * through brown-out pulses, decoded outputs and axi4-lite registers compared.
 * assumes the design package is compiled first; set-up counts shortened.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_option_word_config_decoder;
	import cfg_pkg::*;

	// ------------------------------------------------------------------
	// stimulus tables and shortened set-up counts
	// ------------------------------------------------------------------
	localparam int P18  = 18;
	localparam int P4P5 = 4;
	localparam int P288 = 288;
	localparam int P72  = 72;
	localparam logic [12:0] W0_TAB [4] = '{13'h1FEF, 13'h0A47, 13'h0130, 13'h1C9D};
	localparam logic [1:0]  W1_TAB [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	localparam logic [12:0] ID_TAB [4] = '{13'h0155, 13'h1AAA, 13'h1FFF, 13'h0001};

	logic                  aclk;
	logic                  aresetn;
	logic                  supply_low;
	logic [12:0]           fuse_word0;
	logic [1:0]            fuse_word1;
	logic [12:0]           fuse_id;
	logic                  awvalid, awready, wvalid, wready, bvalid, bready;
	logic                  arvalid, arready, rvalid, rready;
	logic [7:0]            awaddr, araddr;
	logic [31:0]           wdata, rdata;
	logic [3:0]            wstrb;
	logic [1:0]            bresp, rresp;
	logic                  por_release_n, reset_pin_en, watchdog_en, instr_four_clk;
	osc_mode_type          osc_mode;
	logic                  internal_rc_mode, external_rc_mode, high_crystal_mode, low_crystal_mode;
	logic                  code_secure, oscillator_output, port_bit_four_io, readout_grant;
	logic [22:0]           setup_cycles;
	logic [13:0]           irc_freq_khz;
	logic [2:0]            irc_trim_bits;
	logic [12:0]           customer_id;
	int                    fails = 0;
	int                    compares = 0;

	option_word_config_decoder #(.SUT_18MS_CYC(P18), .SUT_4P5MS_CYC(P4P5),
		.SUT_288MS_CYC(P288), .SUT_72MS_CYC(P72)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .supply_low(supply_low),
		.fuse_word0(fuse_word0), .fuse_word1(fuse_word1), .fuse_id(fuse_id),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.por_release_n(por_release_n), .reset_pin_en(reset_pin_en), .watchdog_en(watchdog_en),
		.instr_four_clk(instr_four_clk), .osc_mode(osc_mode), .internal_rc_mode(internal_rc_mode),
		.external_rc_mode(external_rc_mode), .high_crystal_mode(high_crystal_mode),
		.low_crystal_mode(low_crystal_mode), .code_secure(code_secure), .setup_cycles(setup_cycles),
		.oscillator_output(oscillator_output), .port_bit_four_io(port_bit_four_io),
		.irc_freq_khz(irc_freq_khz), .irc_trim_bits(irc_trim_bits), .customer_id(customer_id),
		.readout_grant(readout_grant)
	);

	// 20 MHz clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// ------------------------------------------------------------------
	// checking helpers
	// ------------------------------------------------------------------
	task automatic test_done();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	function automatic logic [22:0] sut_exp(input logic [1:0] s);
		case (s)
			2'h3: sut_exp = 23'(P18);
			2'h2: sut_exp = 23'(P4P5);
			2'h1: sut_exp = 23'(P288);
			default: sut_exp = 23'(P72);
		endcase
	endfunction

	function automatic logic [13:0] freq_exp(input logic [1:0] s);
		case (s)
			2'h3: freq_exp = 14'h0FA0;
			2'h2: freq_exp = 14'h1F40;
			2'h1: freq_exp = 14'h03E8;
			default: freq_exp = 14'h01C7;
		endcase
	endfunction

	// every decoded output against the captured image
	task automatic check_fields(input logic [12:0] w0, input logic [1:0] w1, input logic [12:0] id);
		chk("reset_pin_en", reset_pin_en, !w0[12]);
		chk("watchdog_en", watchdog_en, !w0[11]);
		chk("instr_four_clk", instr_four_clk, w0[10]);
		chk("osc_mode", osc_mode, w0[9:8]);
		chk("mode_flags", {internal_rc_mode, external_rc_mode, high_crystal_mode, low_crystal_mode},
			4'h1 << w0[9:8]);
		chk("code_secure", code_secure, !w0[7]);
		chk("setup_cycles", setup_cycles, sut_exp(w0[6:5]));
		chk("oscillator_output", oscillator_output, w0[3]);
		chk("port_bit_four_io", port_bit_four_io, !w0[3]);
		chk("irc_freq_khz", irc_freq_khz, freq_exp(w1));
		chk("irc_trim_bits", irc_trim_bits, w0[2:0]);
		chk("customer_id", customer_id, id);
	endtask

	// ------------------------------------------------------------------
	// axi4-lite master: handshakes judged before the edge that takes them
	// ------------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ha, hw, hb;
		r = 2'h1;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		wstrb   <= 4'hF;
		bready  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid && bready;
			if (hb) r = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) begin
				bready <= 1'b0;
				break;
			end
		end
		if (n == 64) begin
			fails++;
			test_done();
		end
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		logic ha, hr;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(negedge aclk);
			ha = arvalid && arready;
			hr = rvalid && rready;
			if (hr) chk(name, rdata, d);
			if (hr) chk("rresp", rresp, r);
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			if (hr) begin
				rready <= 1'b0;
				break;
			end
		end
		if (n == 64) begin
			fails++;
			test_done();
		end
	endtask

	// brown-out pulse with a new fuse image, then wait for the recapture
	task automatic recapture(input logic [12:0] w0, input logic [1:0] w1, input logic [12:0] id);
		int n;
		@(posedge aclk);
		fuse_word0 <= w0;
		fuse_word1 <= w1;
		fuse_id    <= id;
		supply_low <= 1'b1;
		@(posedge aclk);
		@(negedge aclk);
		chk("por_release_n", por_release_n, 0);
		@(posedge aclk);
		supply_low <= 1'b0;
		for (n = 0; n < 16 && por_release_n !== 1'b1; n++) @(negedge aclk);
		if (n == 16) begin
			fails++;
			test_done();
		end
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		int i;
		logic [1:0] resp;
		aresetn = 1'b0;
		supply_low = 1'b0;
		fuse_word0 = W0_RST;
		fuse_word1 = W1_RST;
		fuse_id = ID_RST;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		repeat (19) @(posedge aclk);
		@(negedge aclk);
		chk("por_release_n", por_release_n, 0);
		check_fields(W0_RST, W1_RST, ID_RST);
		@(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 16 && por_release_n !== 1'b1; i++) @(negedge aclk);
		chk("por_release_n", por_release_n, 1);
		if (i == 16) test_done();
		for (i = 0; i < 4; i++) begin
			recapture(W0_TAB[i], W1_TAB[i], ID_TAB[i]);
			check_fields(W0_TAB[i], W1_TAB[i], ID_TAB[i]);
			axi_wr(OFS_CTRL, 32'h1, resp);
			chk("bresp", resp, RESP_OKAY);
			@(negedge aclk);
			chk("readout_grant", readout_grant, W0_TAB[i][7]);
			rd_chk("word0", OFS_WORD0, {19'h0, W0_TAB[i]}, RESP_OKAY);
			rd_chk("word1", OFS_WORD1, {30'h0, W1_TAB[i]}, RESP_OKAY);
			rd_chk("id", OFS_ID, {19'h0, ID_TAB[i]}, RESP_OKAY);
			rd_chk("status", OFS_STATUS, {26'h0, W0_TAB[i][9:8], W0_TAB[i][7], W0_TAB[i][4],
				W0_TAB[i][2:0] != TRIM_REQ, 1'b1}, RESP_OKAY);
			axi_wr(OFS_WORD0, 32'h0, resp);
			chk("bresp", resp, RESP_SLVERR);
			rd_chk("word0", OFS_WORD0, {19'h0, W0_TAB[i]}, RESP_OKAY);
			// fuse lines move after capture; outputs must not follow
			@(posedge aclk);
			fuse_word0 <= ~W0_TAB[i];
			fuse_word1 <= ~W1_TAB[i];
			fuse_id <= ~ID_TAB[i];
			repeat (3) @(negedge aclk);
			check_fields(W0_TAB[i], W1_TAB[i], ID_TAB[i]);
		end
		axi_wr(OFS_CTRL, 32'h0, resp);
		@(negedge aclk);
		chk("readout_grant", readout_grant, 0);
		rd_chk("ctrl", OFS_CTRL, 32'h0, RESP_OKAY);
		rd_chk("unmapped", 8'h14, 32'h0, RESP_SLVERR);
		test_done();
	end
endmodule
`default_nettype wire
